/* logic/boost_seq_defs.vh */
/*
 constants for the step-up converter start-up and protection sequencer:
 state codes, timing figures and their cycle counts at the 25 MHz clock.
 assumes it is included by its bare name from the design files.
*/
// Notes on behaviour
// (RULE_01) inrush: source, comparator, timer all on
// (RULE_02) inrush timer expiry goes to fault
// (RULE_03) output near input advances to soft-start
// (RULE_04) soft-start ramps output, current limit on
// (RULE_05) overtemperature overrides all, cool-down enters fault
// (RULE_06) fault keeps output off for timeout
// (RULE_07) fault timeout retries from inrush stage
// (RULE_08) re-enable blocked until output discharged
// (RULE_09) pull-down on while waiting for discharge
// (RULE_10) enable low idles; rising edge starts inrush
// (RULE_11) timers count clock; terminal counts derived
`ifndef BOOST_SEQ_DEFS_VH
`define BOOST_SEQ_DEFS_VH

`define CLK_HZ            25000000
`define INRUSH_TIME_US    1000
`define FAULT_TIME_US     20000
`define DISCHARGE_TIME_US 3000
`define INRUSH_CYCLES     ((`CLK_HZ / 1000000) * `INRUSH_TIME_US)
`define FAULT_CYCLES      ((`CLK_HZ / 1000000) * `FAULT_TIME_US)
`define DISCHARGE_CYCLES  ((`CLK_HZ / 1000000) * `DISCHARGE_TIME_US)

`define TIMER_W           20

`define ST_IDLE           3'h0
`define ST_INRUSH         3'h1
`define ST_SOFTSTART      3'h2
`define ST_RUN            3'h3
`define ST_FAULT          3'h4
`define ST_THERMAL        3'h5
`define ST_DISCHARGE      3'h6

`endif

/* logic/stage_timer.v */
/*
 down-counting stage timer: load a terminal count, count each clock,
 flag expiry. assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "boost_seq_defs.vh"
module stage_timer #(
   parameter W = `TIMER_W
) (
   input  wire         clock,
   input  wire         rstn,
   input  wire         load,
   input  wire [W-1:0] load_value,
   input  wire         run,
   output wire         expired
);
   reg [W-1:0] count;

   always @(posedge clock) begin
      if (!rstn) begin
         count <= {W{1'b0}};
      end else if (load) begin
         count <= load_value;
      end else if (run && count != {W{1'b0}}) begin
         count <= count - {{(W-1){1'b0}}, 1'b1}; // RULE_11
      end
   end

   // kept free of load: the reload is itself decided from expired
   assign expired = run && (count == {W{1'b0}});
endmodule

/* logic/boost_startup_fault_sequencer.v */
/*
 start-up and protection state machine of a step-up converter.
 holds the inrush / soft-start sequence, timed fault with restart,
 thermal shutdown and the discharge lock-out before re-enable.
 assumes comparator and thermal flags are already synchronous to clock.
*/
`timescale 1ns/1ns
`include "boost_seq_defs.vh"
module boost_startup_fault_sequencer #(
   parameter INRUSH_CYCLES = `INRUSH_CYCLES,
   parameter FAULT_CYCLES  = `FAULT_CYCLES
) (
   input  wire       clock,
   input  wire       rstn,
   input  wire       enable,
   input  wire       out_near_in,
   input  wire       out_at_target,
   input  wire       over_temp,
   input  wire       cooled_down,
   output reg        current_source_on,
   output reg        compare_on,
   output reg        current_limit_on,
   output reg        ramp_on,
   output reg        pull_down_on,
   output reg        output_enable,
   output reg  [2:0] state_out
);
   reg  [2:0]          state;
   reg  [2:0]          next_state;
   reg                 enable_prev;
   reg                 has_run;
   reg                 next_has_run;
   reg                 timer_load;
   reg  [`TIMER_W-1:0] timer_value;
   wire                timer_run;
   wire                timer_expired;
   wire                enable_rise;
   wire [5:0]          controls;

   // state codes, shared with the state_out port
   localparam [2:0] IDLE      = `ST_IDLE;
   localparam [2:0] INRUSH    = `ST_INRUSH;
   localparam [2:0] SOFTSTART = `ST_SOFTSTART;
   localparam [2:0] RUN       = `ST_RUN;
   localparam [2:0] FAULT     = `ST_FAULT;
   localparam [2:0] THERMAL   = `ST_THERMAL;
   localparam [2:0] DISCHARGE = `ST_DISCHARGE;

   // a disable lands in the lock-out only once soft-start was reached
   function [2:0] off_state;
      input ran;
      begin
         off_state = ran ? DISCHARGE : IDLE; // RULE_08
      end
   endfunction

   // stages that run on the shared timer
   function timed_state;
      input [2:0] st;
      begin
         timed_state = (st == INRUSH) || (st == FAULT);
      end
   endfunction

   // terminal count for a timed stage; the fault hold is the long one
   function [`TIMER_W-1:0] stage_count;
      input [2:0] st;
      begin
         if (st == FAULT) begin
            stage_count = FAULT_CYCLES[`TIMER_W-1:0]; // RULE_06
         end else begin
            stage_count = INRUSH_CYCLES[`TIMER_W-1:0]; // RULE_02
         end
      end
   endfunction

   // power stage controls: source, compare, limit, ramp, pull-down, output
   function [5:0] stage_controls;
      input [2:0] st;
      begin
         case (st)
            INRUSH:    stage_controls = 6'h30; // RULE_01
            SOFTSTART: stage_controls = 6'h0d; // RULE_04
            RUN:       stage_controls = 6'h01;
            DISCHARGE: stage_controls = 6'h12; // RULE_09
            default:   stage_controls = 6'h00; // RULE_06
         endcase
      end
   endfunction

   // a level held high after a discharge does not restart
   assign enable_rise = enable && !enable_prev;
   assign timer_run   = timed_state(state); // RULE_11
   assign controls    = stage_controls(next_state);

   stage_timer #(
      .W (`TIMER_W)
   ) i_stage_timer (
      .clock      (clock),
      .rstn       (rstn),
      .load       (timer_load),
      .load_value (timer_value),
      .run        (timer_run),
      .expired    (timer_expired)
   );

   // next state; thermal takes precedence over every other state
   always @* begin
      next_state = state;
      if (over_temp && state != THERMAL) begin
         next_state = THERMAL; // RULE_05
      end else begin
         case (state)
            IDLE: begin
               if (enable_rise && !has_run) begin
                  next_state = INRUSH; // RULE_10
               end
            end
            INRUSH: begin
               if (!enable) begin
                  next_state = off_state(has_run);
               end else if (out_near_in) begin
                  next_state = SOFTSTART; // RULE_03
               end else if (timer_expired) begin
                  next_state = FAULT; // RULE_02
               end
            end
            SOFTSTART: begin
               if (!enable) begin
                  next_state = DISCHARGE; // RULE_08
               end else if (out_at_target) begin
                  next_state = RUN; // RULE_04
               end
            end
            RUN: begin
               if (!enable) begin
                  next_state = DISCHARGE; // RULE_08
               end
            end
            FAULT: begin
               if (timer_expired) begin
                  if (enable) begin
                     next_state = INRUSH; // RULE_07
                  end else begin
                     next_state = off_state(has_run);
                  end
               end
            end
            THERMAL: begin
               if (cooled_down && !over_temp) begin
                  next_state = FAULT; // RULE_05
               end
            end
            DISCHARGE: begin
               // enable is ignored here until the output has dropped out of near-input
               if (!out_near_in) begin
                  next_state = IDLE; // RULE_08
               end
            end
            default: begin
               next_state = IDLE;
            end
         endcase
      end
   end

   // reload on every entry into a timed stage, from whichever state
   always @* begin
      timer_load  = 1'b0;
      timer_value = stage_count(next_state); // RULE_11
      if (timed_state(next_state) && next_state != state) begin
         timer_load = 1'b1; // RULE_01
      end
   end

   // a level already high at reset release counts as a rise
   always @(posedge clock) begin
      if (!rstn) begin
         enable_prev <= 1'b0;
      end else begin
         enable_prev <= enable;
      end
   end

   // lock-out memory: set in soft-start, cleared once discharged
   always @* begin
      next_has_run = has_run;
      if (state == SOFTSTART) begin
         next_has_run = 1'b1; // RULE_08
      end else if (state == DISCHARGE && next_state == IDLE) begin
         next_has_run = 1'b0; // RULE_08
      end
   end

   always @(posedge clock) begin
      if (!rstn) begin
         state   <= `ST_IDLE;
         has_run <= 1'b0;
      end else begin
         state   <= next_state;
         has_run <= next_has_run;
      end
   end

   // outputs registered from the next state, so they line up with state
   always @(posedge clock) begin
      if (!rstn) begin
         current_source_on <= 1'b0;
         compare_on        <= 1'b0;
         current_limit_on  <= 1'b0;
         ramp_on           <= 1'b0;
         pull_down_on      <= 1'b0;
         output_enable     <= 1'b0;
         state_out         <= `ST_IDLE;
      end else begin
         current_source_on <= controls[5]; // RULE_01
         compare_on        <= controls[4]; // RULE_01
         current_limit_on  <= controls[3]; // RULE_04
         ramp_on           <= controls[2]; // RULE_04
         pull_down_on      <= controls[1]; // RULE_09
         // fault, thermal and idle all keep the output switched off
         output_enable     <= controls[0]; // RULE_06
         state_out         <= next_state;
      end
   end
endmodule

/* verif/boost_seq_sva.sv */
/* assertions on the sequencer ports.
 assumes one clock and synchronous active-low rstn. */
`timescale 1ns/1ns
module boost_seq_sva #(parameter INRUSH_CYCLES = 20, parameter FAULT_CYCLES = 40) (
   input wire       clock, rstn, enable, out_near_in, out_at_target, over_temp,
   input wire       cooled_down, current_source_on, compare_on, current_limit_on,
   input wire       ramp_on, pull_down_on, output_enable,
   input wire [2:0] state_out
);
   reg [19:0] ic;
   reg [19:0] fc;
   always @(posedge clock) begin
      ic <= (rstn && state_out == 3'h1) ? ic + 20'h1 : 20'h0;
      fc <= (rstn && state_out == 3'h4) ? fc + 20'h1 : 20'h0;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_inrush_drive: assert property (state_out == 3'h1 |-> current_source_on && compare_on
      && !output_enable) else $error("inrush drive");
   a_inrush_bound: assert property (ic <= INRUSH_CYCLES + 1) else $error("inrush long");
   a_near_advance: assert property (state_out == 3'h1 && out_near_in && enable && !over_temp
      |=> state_out == 3'h2) else $error("no soft-start");
   a_soft_limit: assert property (state_out == 3'h2 |-> current_limit_on && ramp_on
      && output_enable) else $error("soft-start drive");
   a_heat_override: assert property (over_temp |=> state_out == 3'h5) else $error("no thermal");
   a_cool_fault: assert property (state_out == 3'h5 && cooled_down && !over_temp
      |=> state_out == 3'h4) else $error("no fault after cool");
   a_fault_hold: assert property (state_out == 3'h4 |-> !output_enable
      && fc <= FAULT_CYCLES + 1) else $error("fault hold");
   a_fault_retry: assert property ($fell(state_out == 3'h4) && $past(enable)
      && !$past(over_temp) |-> state_out == 3'h1) else $error("retry not inrush");
   a_discharge_lock: assert property (state_out == 3'h6 && out_near_in && !over_temp
      |=> state_out == 3'h6) else $error("lock-out broken");
   a_discharge_pull: assert property (state_out == 3'h6 |-> pull_down_on
      && !output_enable) else $error("pull-down off");
   a_idle_off: assert property (state_out == 3'h0 |-> !output_enable
      && !current_source_on) else $error("idle drive");
endmodule
bind boost_startup_fault_sequencer boost_seq_sva #(.INRUSH_CYCLES(INRUSH_CYCLES),
   .FAULT_CYCLES(FAULT_CYCLES)) i_boost_seq_sva (.clock(clock), .rstn(rstn),
   .enable(enable), .out_near_in(out_near_in), .out_at_target(out_at_target),
   .over_temp(over_temp), .cooled_down(cooled_down), .current_source_on(current_source_on),
   .compare_on(compare_on), .current_limit_on(current_limit_on), .ramp_on(ramp_on),
   .pull_down_on(pull_down_on), .output_enable(output_enable), .state_out(state_out));

/* verif/power_stage_model.sv */
/* behavioural output node and comparators of the power stage.
 assumes dly sets how far the output must charge before it nears input. */
`timescale 1ns/1ns
module power_stage_model (
   input wire       clock, current_source_on, output_enable, ramp_on, pull_down_on,
   input wire [7:0] dly,
   output reg       out_near_in,
   output reg       out_at_target
);
   reg [7:0] lvl = 8'h00;
   reg [2:0] t = 3'h0;
   initial out_near_in = 1'b0;
   initial out_at_target = 1'b0;
   always @(posedge clock) begin
      // boost lifts output well above input, so discharge takes a while
      if ((current_source_on || output_enable) && lvl != 8'hff) lvl <= lvl + 8'h01;
      else if (pull_down_on && lvl != 8'h00) lvl <= lvl - 8'h01;
      out_near_in <= (lvl >= dly);
      t <= ramp_on ? t + {2'h0, t != 3'h7} : 3'h0;
      out_at_target <= (t >= 3'h4);
   end
endmodule

/* verif/test_boost_startup_fault_sequencer.sv */
/* self-checking bench of the sequencer with a power stage model.
 assumes the shortened timer parameters below. */
`timescale 1ns/1ns
`define CHK(s, e, v) begin checks++; if ((v) !== (e)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", s, e, v); end end
module test_boost_startup_fault_sequencer;
   reg clock = 0, rstn = 0, enable = 0, over_temp = 0, cooled_down = 0;
   reg [7:0] dly = 8'h05;
   reg [31:0] rnd = 32'd17825;
   integer fails = 0, checks = 0, cyc = 0, n;
   wire near, tgt, src, cmp, lim, rmp, pd, oe;
   wire [2:0] st;
   initial forever #20 clock = ~clock;
   boost_startup_fault_sequencer #(.INRUSH_CYCLES(20), .FAULT_CYCLES(40))
      i_boost_startup_fault_sequencer (.clock(clock), .rstn(rstn), .enable(enable),
      .out_near_in(near), .out_at_target(tgt), .over_temp(over_temp),
      .cooled_down(cooled_down), .current_source_on(src), .compare_on(cmp),
      .current_limit_on(lim), .ramp_on(rmp), .pull_down_on(pd), .output_enable(oe),
      .state_out(st));
   power_stage_model i_power_stage_model (.clock(clock), .current_source_on(src),
      .output_enable(oe), .ramp_on(rmp), .pull_down_on(pd), .dly(dly),
      .out_near_in(near), .out_at_target(tgt));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task complete_run;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task till(input [2:0] s);
      begin
         n = 0;
         while (st !== s && n < 600) begin
            @(negedge clock);
            n = n + 1;
         end
         if (st !== s) begin
            fails++;
            $display("[ERR] state wait exp %0h got %0h", s, st);
         end
      end
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         complete_run;
      end
   end
   initial begin
      repeat (12) @(negedge clock);
      rstn = 1;
      repeat (2) @(negedge clock);
      repeat (4) begin
         rnd = xs(rnd);
         dly = {4'h0, rnd[3:0]} + 8'h02;
         enable = 1;
         till(3'h1);
         `CHK("inrush src", 1'b1, src)
         `CHK("inrush cmp", 1'b1, cmp)
         till(3'h2);
         `CHK("limit", 1'b1, lim)
         `CHK("ramp", 1'b1, rmp)
         till(3'h3);
         `CHK("run", 3'h3, st)
         enable = 0;
         repeat (3) @(negedge clock);
         enable = 1;
         repeat (2) @(negedge clock);
         `CHK("lock", 3'h6, st)
         `CHK("pull", 1'b1, pd)
         `CHK("discharge cmp", 1'b1, cmp)
         till(3'h0);
         `CHK("idle", 3'h0, st)
         enable = 0;
         @(negedge clock);
      end
      dly = 8'hff;
      enable = 1;
      till(3'h1);
      till(3'h4);
      `CHK("inrush len", 1'b1, n >= 19 && n <= 21)
      till(3'h1);
      `CHK("fault len", 1'b1, n >= 39 && n <= 41)
      `CHK("retry", 3'h1, st)
      over_temp = 1;
      repeat (2) @(negedge clock);
      `CHK("thermal", 3'h5, st)
      over_temp = 0;
      cooled_down = 1;
      repeat (2) @(negedge clock);
      `CHK("cooled", 3'h4, st)
      cooled_down = 0;
      enable = 0;
      till(3'h0);
      `CHK("end idle", 1'b0, oe)
      complete_run;
   end
endmodule
